// *** hdl/fcoc_pkg.sv ***
// Shared constants and carriers for the frame and chip offset calculator.
// Assumes a single 125 MHz clock and a one-cycle frame tick from outside.
package fcoc_pkg;
  localparam int unsigned FRAME_CHIPS      = 38400;
  localparam int unsigned SHIFT_UNIT_CHIPS = 512;
  localparam int unsigned HALF_UNIT_CHIPS  = 256;
  localparam int unsigned CFN_MOD          = 256;
  localparam int unsigned SFN_W            = 12;
  localparam int unsigned CFN_W            = 8;
  localparam int unsigned SHIFT_W          = 9;
  localparam int unsigned CHIP_W           = 16;
  localparam int unsigned SUM_W            = 24;
  localparam int unsigned FO_W             = 9;
  localparam logic [7:0]  TDD_NEW_LINK_OFF = 8'h00;
  localparam logic [7:0]  CFN_RESET        = 8'h00;
  localparam logic [11:0] SFN_RESET        = 12'h000;

  // Kind of offset calculation requested
  typedef enum logic [3:0] {
    FCOC_OP_SETUP   = 4'h1,
    FCOC_OP_TARGET  = 4'h2,
    FCOC_OP_TDD     = 4'h4,
    FCOC_OP_FOREIGN = 4'h8
  } fcoc_op_type;

  typedef struct packed {
    fcoc_op_type         op;
    logic [SHIFT_W-1:0]  shift;
    logic [CFN_W-1:0]    frame_diff;
    logic [CHIP_W-1:0]   chip_diff;
    logic                diff_known;
    logic                add_half;
  } fcoc_req_type;

  typedef struct packed {
    logic [FO_W-1:0]   frame_offset;
    logic [CHIP_W-1:0] chip_offset;
  } fcoc_res_type;
endpackage : fcoc_pkg

// *** hdl/fcoc_divider.sv ***
// Splits a chip sum into whole frames and leftover chips, one bit per cycle.
// Assumes start is only given while ready is high.
`timescale 1ns/100ps
module fcoc_divider #(
  parameter int unsigned SUM_W = fcoc_pkg::SUM_W
) (
  input  wire logic                      clk_in,
  input  wire logic                      resetn_in,
  input  wire logic                      start_in,
  input  wire logic [SUM_W-1:0]          sum_in,
  output logic                           ready_out,
  output logic                           done_out,
  output fcoc_pkg::fcoc_res_type         res_out
);
  typedef struct packed {
    logic [SUM_W-1:0]   rem;
    logic [SUM_W-1:0]   quo;
    logic [4:0]         bit_idx;
    logic               busy;
    logic               done;
  } fcoc_div_state_type;

  localparam logic [SUM_W-1:0] FRAME = SUM_W'(fcoc_pkg::FRAME_CHIPS);

  fcoc_div_state_type state;
  fcoc_div_state_type next_state;
  logic [SUM_W-1:0]   trial;

  ////////////////////////////////////////////////////////////////////////
  // Restoring division by frame
  always_comb begin
    next_state      = state;
    next_state.done = 1'b0;
    trial           = {state.rem[SUM_W-2:0], state.quo[SUM_W-1]};
    if (start_in && !state.busy) begin
      next_state.rem     = '0;
      next_state.quo     = sum_in;
      next_state.bit_idx = 5'(SUM_W - 1);
      next_state.busy    = 1'b1;
    end else if (state.busy) begin
      next_state.quo = {state.quo[SUM_W-2:0], 1'b0};
      if (trial >= FRAME) begin
        next_state.rem    = trial - FRAME;
        next_state.quo[0] = 1'b1;
      end else begin
        next_state.rem = trial;
      end
      if (state.bit_idx == 5'h00) begin
        next_state.busy = 1'b0;
        next_state.done = 1'b1;
      end else begin
        next_state.bit_idx = state.bit_idx - 5'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign ready_out                = !state.busy;
  assign done_out                 = state.done;
  assign res_out.frame_offset     = state.quo[fcoc_pkg::FO_W-1:0];
  assign res_out.chip_offset      = state.rem[fcoc_pkg::CHIP_W-1:0];

  a_chip_below_frame: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state.done |-> state.rem < FRAME) else $error("chip offset not below one frame");
endmodule : fcoc_divider

// *** hdl/fcoc_calc.sv ***
// Serving controller offset calculator, common channel counters and L1 switch.
// Assumes frame_tick_in pulses once per radio frame; requests held until taken.
`timescale 1ns/100ps
module fcoc_calc (
  input  wire logic                      clk_in,
  input  wire logic                      resetn_in,
  input  wire logic                      frame_tick_in,
  input  wire logic                      req_valid_in,
  input  wire fcoc_pkg::fcoc_req_type    req_in,
  input  wire logic                      cnt_load_in,
  input  wire logic [fcoc_pkg::SFN_W-1:0] sfn_in,
  input  wire logic                      recfg_req_in,
  input  wire logic                      prep_done_in,
  input  wire logic [fcoc_pkg::CFN_W-1:0] switch_cfn_in,
  output logic                           req_ready_out,
  output logic                           res_valid_out,
  output fcoc_pkg::fcoc_res_type         res_out,
  output logic                           send_shift_out,
  output logic [fcoc_pkg::SFN_W-1:0]     paging_cfn_out,
  output logic [fcoc_pkg::CFN_W-1:0]     common_cfn_out,
  output logic                           prep_req_out,
  output logic                           switch_valid_out,
  output logic [fcoc_pkg::CFN_W-1:0]     switch_cfn_out,
  output logic                           apply_cfg_out
);
  typedef enum logic [3:0] {
    FCOC_SW_IDLE    = 4'h1,
    FCOC_SW_PREPARE = 4'h2,
    FCOC_SW_ARMED   = 4'h4,
    FCOC_SW_APPLY   = 4'h8
  } fcoc_sw_type;

  typedef struct packed {
    logic                          busy;
    logic                          tdd_path;
    logic                          res_valid;
    fcoc_pkg::fcoc_res_type        res;
    logic                          send_shift;
    logic [fcoc_pkg::SFN_W-1:0]    paging_cfn;
    logic [fcoc_pkg::CFN_W-1:0]    common_cfn;
    fcoc_sw_type                   sw;
    logic [fcoc_pkg::CFN_W-1:0]    switch_cfn;
    logic                          switch_valid;
    logic                          apply_cfg;
    logic                          ready;
    logic                          prep_req;
  } fcoc_state_type;

  localparam logic [fcoc_pkg::SUM_W-1:0] FRAME = fcoc_pkg::SUM_W'(fcoc_pkg::FRAME_CHIPS);
  localparam logic [fcoc_pkg::SUM_W-1:0] UNIT  = fcoc_pkg::SUM_W'(fcoc_pkg::SHIFT_UNIT_CHIPS);
  localparam logic [fcoc_pkg::SUM_W-1:0] HALF  = fcoc_pkg::SUM_W'(fcoc_pkg::HALF_UNIT_CHIPS);

  fcoc_state_type               state;
  fcoc_state_type               next_state;
  logic                         div_start;
  logic [fcoc_pkg::SUM_W-1:0]   div_sum;
  logic                         div_ready;
  logic                         div_done;
  fcoc_pkg::fcoc_res_type       div_res;
  logic                         take;

  // Chip sum for frequency-division requests
  function automatic logic [fcoc_pkg::SUM_W-1:0] chip_sum(input fcoc_pkg::fcoc_req_type r);
    logic [fcoc_pkg::SUM_W-1:0] s;
    s = '0;
    case (r.op)
      fcoc_pkg::FCOC_OP_TARGET: begin
        if (r.diff_known) begin
          s = fcoc_pkg::SUM_W'(r.frame_diff) * FRAME + fcoc_pkg::SUM_W'(r.chip_diff);
        end else begin
          s = fcoc_pkg::SUM_W'(r.shift) * UNIT;
        end
      end
      default: begin
        s = fcoc_pkg::SUM_W'(r.shift) * UNIT + fcoc_pkg::SUM_W'(r.frame_diff) * FRAME
          + fcoc_pkg::SUM_W'(r.chip_diff);
        if (r.add_half) begin
          s = s + HALF;
        end
      end
    endcase
    return s;
  endfunction : chip_sum

  ////////////////////////////////////////////////////////////////////////
  assign take      = req_valid_in && !state.busy && div_ready;
  assign div_start = take && (req_in.op != fcoc_pkg::FCOC_OP_TDD) && (req_in.op != fcoc_pkg::FCOC_OP_FOREIGN);
  assign div_sum   = chip_sum(req_in);

  fcoc_divider #(
    .SUM_W(fcoc_pkg::SUM_W)
  ) u_div (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .start_in  (div_start),
    .sum_in    (div_sum),
    .ready_out (div_ready),
    .done_out  (div_done),
    .res_out   (div_res)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state           = state;
    next_state.res_valid = 1'b0;
    next_state.apply_cfg = 1'b0;
    if (take) begin
      next_state.busy       = 1'b1;
      next_state.send_shift = (req_in.op == fcoc_pkg::FCOC_OP_TARGET) && !req_in.diff_known;
      if (req_in.op == fcoc_pkg::FCOC_OP_TDD) begin
        next_state.res.frame_offset = req_in.diff_known ? fcoc_pkg::FO_W'(req_in.frame_diff)
                                                        : fcoc_pkg::FO_W'(req_in.shift);
        next_state.res.chip_offset  = '0;
        next_state.tdd_path         = 1'b1;
      end else if (req_in.op == fcoc_pkg::FCOC_OP_FOREIGN) begin
        next_state.res.frame_offset = fcoc_pkg::FO_W'(fcoc_pkg::TDD_NEW_LINK_OFF);
        next_state.res.chip_offset  = '0;
        next_state.tdd_path         = 1'b1;
      end else begin
        next_state.tdd_path = 1'b0;
      end
    end else if (state.busy && (state.tdd_path || div_done)) begin
      if (!state.tdd_path) begin
        next_state.res = div_res;
      end
      next_state.busy      = 1'b0;
      next_state.res_valid = 1'b1;
    end
    if (cnt_load_in) begin
      next_state.paging_cfn = sfn_in;
      next_state.common_cfn = sfn_in[fcoc_pkg::CFN_W-1:0];
    end else if (frame_tick_in) begin
      next_state.paging_cfn = state.paging_cfn + 12'h001;
      next_state.common_cfn = state.common_cfn + 8'h01;
    end
    case (state.sw)
      FCOC_SW_IDLE: begin
        if (recfg_req_in) begin
          next_state.sw = FCOC_SW_PREPARE;
        end
      end
      FCOC_SW_PREPARE: begin
        if (prep_done_in) begin
          next_state.switch_cfn   = switch_cfn_in;
          next_state.switch_valid = 1'b1;
          next_state.sw           = FCOC_SW_ARMED;
        end
      end
      FCOC_SW_ARMED: begin
        if (frame_tick_in && (next_state.common_cfn == state.switch_cfn)) begin
          next_state.apply_cfg    = 1'b1;
          next_state.switch_valid = 1'b0;
          next_state.sw           = FCOC_SW_APPLY;
        end
      end
      FCOC_SW_APPLY: begin
        next_state.sw = FCOC_SW_IDLE;
      end
      default: begin
        next_state.sw = FCOC_SW_IDLE;
      end
    endcase
    // Decoded ahead of the edge so outputs leave flops
    next_state.ready    = !next_state.busy;
    next_state.prep_req = (next_state.sw == FCOC_SW_PREPARE);
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state            <= '0;
      state.sw         <= FCOC_SW_IDLE;
      state.ready      <= 1'b1;
      state.paging_cfn <= fcoc_pkg::SFN_RESET;
      state.common_cfn <= fcoc_pkg::CFN_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign req_ready_out    = state.ready;
  assign res_valid_out    = state.res_valid;
  assign res_out          = state.res;
  assign send_shift_out   = state.send_shift;
  assign paging_cfn_out   = state.paging_cfn;
  assign common_cfn_out   = state.common_cfn;
  assign prep_req_out     = state.prep_req;
  assign switch_valid_out = state.switch_valid;
  assign switch_cfn_out   = state.switch_cfn;
  assign apply_cfg_out    = state.apply_cfg;

  ////////////////////////////////////////////////////////////////////////
  sequence s_armed_hit;
    state.sw == FCOC_SW_ARMED ##0 frame_tick_in ##0 !cnt_load_in;
  endsequence

  a_tdd_known_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    take && req_in.op == fcoc_pkg::FCOC_OP_TDD && req_in.diff_known |=> ##1 res_valid_out
    && res_out.frame_offset == fcoc_pkg::FO_W'($past(req_in.frame_diff, 2))) else $error("tdd offset wrong");
  a_foreign_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    take && req_in.op == fcoc_pkg::FCOC_OP_FOREIGN |=> ##1 res_out.frame_offset == '0) else $error("foreign not zero");
  a_common_step: assert property (@(posedge clk_in) disable iff (!resetn_in)
    frame_tick_in && !cnt_load_in |=> common_cfn_out == $past(common_cfn_out) + 8'h01) else $error("common step");
  a_load_start: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cnt_load_in |=> paging_cfn_out == $past(sfn_in) && common_cfn_out == $past(sfn_in[7:0])) else $error("load");
  a_shift_send: assert property (@(posedge clk_in) disable iff (!resetn_in)
    take && req_in.op == fcoc_pkg::FCOC_OP_TARGET |=> send_shift_out == !$past(req_in.diff_known)) else $error("shift");
  a_fd_result: assert property (@(posedge clk_in) disable iff (!resetn_in)
    res_valid_out && !state.tdd_path |-> res_out.chip_offset < 16'(fcoc_pkg::FRAME_CHIPS)) else $error("chip range");
  a_fd_latency: assert property (@(posedge clk_in) disable iff (!resetn_in)
    div_start |-> ##26 res_valid_out) else $error("divide latency");
  a_switch_apply: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_armed_hit ##0 (common_cfn_out + 8'h01 == switch_cfn_out) |=> apply_cfg_out) else $error("no apply");
  a_prep_first: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(switch_valid_out) |-> $past(prep_req_out) && $past(prep_done_in)) else $error("switch before prep");
endmodule : fcoc_calc

// *** testbench/fcoc_station_model.sv ***
// Behavioural base station that prepares for an L1 change.
// Assumes prep_req_in stays high until the switch frame is chosen.
`timescale 1ns/100ps
module fcoc_station_model (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic prep_req_in,
  input  wire logic slow_in,
  output logic      prep_done_out
);
  logic [7:0] cnt;
  logic       sent;
  //////////////////////////////////////////////////////////////
  // Report preparation done once
  always_ff @(posedge clk_in) begin
    prep_done_out <= 1'b0;
    if (!resetn_in || !prep_req_in) begin
      cnt  <= 8'h00;
      sent <= 1'b0;
    end else if (!sent) begin
      cnt <= cnt + 8'h01;
      if (cnt == (slow_in ? 8'h06 : 8'h01)) begin
        prep_done_out <= 1'b1;
        sent          <= 1'b1;
      end
    end
  end
endmodule : fcoc_station_model

// *** testbench/fcoc_calc_bench.sv ***
// Self-checking bench for the offset calculator, counters and L1 switch.
// Assumes the station model answers preparation requests.
`timescale 1ns/100ps
module fcoc_calc_bench;
  localparam int unsigned FC = fcoc_pkg::FRAME_CHIPS;
  logic                   clk_in        = 1'b0;
  logic                   resetn_in     = 1'b0;
  logic                   frame_tick_in = 1'b0;
  logic                   req_valid_in  = 1'b0;
  fcoc_pkg::fcoc_req_type req_in        = '0;
  logic                   cnt_load_in   = 1'b0;
  logic [11:0]            sfn_in        = 12'h000;
  logic                   recfg_req_in  = 1'b0;
  logic [7:0]             switch_cfn_in = 8'h00;
  logic                   slow          = 1'b0;
  logic                   prep_done_in;
  logic                   req_ready_out, res_valid_out, send_shift_out;
  logic                   prep_req_out, switch_valid_out, apply_cfg_out;
  fcoc_pkg::fcoc_res_type res_out;
  logic [11:0]            paging_cfn_out;
  logic [7:0]             common_cfn_out, switch_cfn_out;
  int                     num_errors = 0;
  int                     n_checks   = 0;

  always #4 clk_in = ~clk_in;

  fcoc_calc dut (.clk_in(clk_in), .resetn_in(resetn_in), .frame_tick_in(frame_tick_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .cnt_load_in(cnt_load_in), .sfn_in(sfn_in),
    .recfg_req_in(recfg_req_in), .prep_done_in(prep_done_in), .switch_cfn_in(switch_cfn_in),
    .req_ready_out(req_ready_out), .res_valid_out(res_valid_out), .res_out(res_out),
    .send_shift_out(send_shift_out), .paging_cfn_out(paging_cfn_out), .common_cfn_out(common_cfn_out),
    .prep_req_out(prep_req_out), .switch_valid_out(switch_valid_out), .switch_cfn_out(switch_cfn_out),
    .apply_cfg_out(apply_cfg_out));

  fcoc_station_model station (.clk_in(clk_in), .resetn_in(resetn_in), .prep_req_in(prep_req_out),
    .slow_in(slow), .prep_done_out(prep_done_in));

  //////////////////////////////////////////////////////////////
  task end_sim;
    $display("Counts: %0d mismatches in %0d comparisons", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  task nclk(input int n);
    repeat (n) @(negedge clk_in);
  endtask : nclk

  task load(input logic [11:0] s);
    sfn_in = s;
    cnt_load_in = 1'b1;
    nclk(1);
    cnt_load_in = 1'b0;
  endtask : load

  task tick;
    frame_tick_in = 1'b1;
    nclk(1);
    frame_tick_in = 1'b0;
  endtask : tick

  //////////////////////////////////////////////////////////////
  // Terminal frame number load, frequency division
  function automatic logic [7:0] term_cfn_fdd(input logic [11:0] system_frame_number, input logic [8:0] sh);
    int unsigned lag;
    lag = (sh * 512) / FC;
    return 8'(system_frame_number - lag);
  endfunction : term_cfn_fdd

  // Terminal frame number load, time division
  function automatic logic [7:0] term_cfn_tdd(input logic [11:0] system_frame_number, input logic [8:0] sh);
    return 8'(system_frame_number - sh);
  endfunction : term_cfn_tdd

  function automatic logic [7:0] term_diff(input logic [11:0] sfn_t, input logic [7:0] connection_frame_number);
    return 8'(sfn_t - connection_frame_number);
  endfunction : term_diff

  //////////////////////////////////////////////////////////////
  // Expected offsets for setup and target requests are rebuilt here from the chip arithmetic
  task automatic do_req(input fcoc_pkg::fcoc_op_type op, input logic [8:0] sh, input logic [7:0] fd,
                        input logic [15:0] cd, input logic kn, input logic hf);
    int unsigned sum;
    int          lat;
    int          k;
    logic [8:0]  efo;
    sum = 0;
    lat = 2;
    efo = kn ? {1'b0, fd} : sh;
    if (op == fcoc_pkg::FCOC_OP_FOREIGN) efo = 9'h000;
    if (op == fcoc_pkg::FCOC_OP_SETUP) sum = sh * 512 + fd * FC + cd + hf * 256;
    if (op == fcoc_pkg::FCOC_OP_TARGET) sum = kn ? fd * FC + cd : sh * 512;
    if (op == fcoc_pkg::FCOC_OP_SETUP || op == fcoc_pkg::FCOC_OP_TARGET) begin
      lat = 26;
      efo = 9'(sum / FC);
    end
    req_in = '{op, sh, fd, cd, kn, hf};
    req_valid_in = 1'b1;
    k = 0;
    while (req_ready_out !== 1'b1 && k < 40) begin
      nclk(1);
      k++;
    end
    chk(req_ready_out === 1'b1, "request taken");
    if (k >= 40) end_sim;
    nclk(1);
    req_valid_in = 1'b0;
    k = 1;
    while (res_valid_out !== 1'b1 && k < 40) begin
      nclk(1);
      k++;
    end
    chk(k == lat, "answer latency");
    chk(res_out.frame_offset === efo, "frame offset");
    if (lat == 26) chk(res_out.chip_offset === 16'(sum % FC), "chip offset");
    if (op == fcoc_pkg::FCOC_OP_TARGET) chk(send_shift_out === !kn, "shift flag");
    if (k >= 40) end_sim;
  endtask : do_req

  task t_offsets;
    do_req(fcoc_pkg::FCOC_OP_SETUP, 9'h000, 8'h00, 16'h0000, 1'b1, 1'b0);
    do_req(fcoc_pkg::FCOC_OP_SETUP, 9'h1FF, 8'h00, 16'h0000, 1'b1, 1'b1);
    do_req(fcoc_pkg::FCOC_OP_SETUP, 9'h04B, 8'h03, 16'h95FF, 1'b1, 1'b1);
    do_req(fcoc_pkg::FCOC_OP_SETUP, 9'h000, 8'hFF, 16'h95FF, 1'b1, 1'b0);
    do_req(fcoc_pkg::FCOC_OP_TARGET, 9'h0AA, 8'h07, 16'h1234, 1'b1, 1'b0);
    do_req(fcoc_pkg::FCOC_OP_TARGET, 9'h0AA, 8'h07, 16'h1234, 1'b0, 1'b0);
    do_req(fcoc_pkg::FCOC_OP_TDD, 9'h133, 8'h21, 16'h0000, 1'b1, 1'b0);
    do_req(fcoc_pkg::FCOC_OP_TDD, 9'h133, 8'h21, 16'h0000, 1'b0, 1'b0);
    do_req(fcoc_pkg::FCOC_OP_FOREIGN, 9'h133, 8'h21, 16'h0000, 1'b1, 1'b0);
  endtask : t_offsets

  // Terminal arithmetic produces the differences the controller gets
  task automatic t_terminal;
    logic [7:0] connection_frame_number;
    do_req(fcoc_pkg::FCOC_OP_SETUP, 9'h096, term_diff(12'h2C7, 8'h5A), 16'h0100, 1'b1, 1'b0);
    // Load only after all cells measured
    connection_frame_number = term_cfn_fdd(12'h25A, 9'h096);
    connection_frame_number = connection_frame_number + 8'h01;
    do_req(fcoc_pkg::FCOC_OP_TARGET, 9'h096, term_diff(12'h8E1, connection_frame_number), 16'h3FFF, 1'b1, 1'b0);
    // Unknown difference, terminal reloads after handover
    do_req(fcoc_pkg::FCOC_OP_TARGET, 9'h0C8, 8'h00, 16'h0000, 1'b0, 1'b0);
    connection_frame_number = term_cfn_fdd(12'h1F4, 9'h0C8);
    do_req(fcoc_pkg::FCOC_OP_TARGET, 9'h0C8, term_diff(12'h300, connection_frame_number), 16'h0080, 1'b1, 1'b0);
    connection_frame_number = term_cfn_tdd(12'h0C0, 9'h011);
    do_req(fcoc_pkg::FCOC_OP_TDD, 9'h011, term_diff(12'h0D5, connection_frame_number), 16'h0000, 1'b1, 1'b0);
  endtask : t_terminal

  // First load at the top of both ranges, second at the top of the common range only, so the wraps show
  task t_counters;
    load(12'hFFF);
    chk(paging_cfn_out === 12'hFFF && common_cfn_out === 8'hFF, "counter load");
    tick;
    chk(paging_cfn_out === 12'h000 && common_cfn_out === 8'h00, "counter wrap");
    load(12'h1FF);
    chk(common_cfn_out === 8'hFF, "common equals terminal view");
    tick;
    chk(paging_cfn_out === 12'h200 && common_cfn_out === 8'h00, "common wrap");
  endtask : t_counters

  task automatic t_switch(input logic sl);
    int k;
    slow = sl;
    load(12'h310);
    switch_cfn_in = 8'h13;
    recfg_req_in = 1'b1;
    nclk(1);
    recfg_req_in = 1'b0;
    chk(prep_req_out === 1'b1, "stations asked to prepare");
    k = 0;
    while (switch_valid_out !== 1'b1 && k < 20) begin
      nclk(1);
      k++;
    end
    chk(switch_valid_out === 1'b1 && switch_cfn_out === 8'h13, "switch frame sent");
    if (k >= 20) end_sim;
    for (int i = 0; i < 3; i++) begin
      tick;
      chk(apply_cfg_out === (i == 2), "apply at switch frame only");
    end
    nclk(1);
    chk(apply_cfg_out === 1'b0 && switch_valid_out === 1'b0, "switch finished");
  endtask : t_switch

  //////////////////////////////////////////////////////////////
  initial begin
    nclk(4);
    resetn_in = 1'b1;
    nclk(1);
    chk(req_ready_out === 1'b1 && res_valid_out === 1'b0 && common_cfn_out === 8'h00, "reset state");
    t_offsets;
    t_terminal;
    t_counters;
    t_switch(1'b0);
    t_switch(1'b1);
    end_sim;
  end
endmodule : fcoc_calc_bench
